// ### logic/atxs_top.sv
// Purpose: Transmit data ready, DMA request, interrupt and digital audio bit selection
// Assumes: APB slave with zero wait states; all serializers run in lockstep
// Notes: Buffers reachable from the data port or APB, chosen by the port select bit
//
// What this block does
// - Buffer to shift transfer sets empty flag
// - Write one or all written clears flag
// - Flag set raises a DMA request
// - Flag set raises interrupt when enabled
// - Every transfer requests again, no status read
// - One request covers all serializers
// - Request appears within five clocks
// - Buffers reachable from data port and APB
// - Any requester on either port accepted
// - Status/user bit from word f/32, bit f%32
// - Data port walks active serializers ascending
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module atxs_top (
    input wire logic pclk, // System clock, 125 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic dp_wvalid, // Data port write request
    input wire atxs_pkg::atxs_word_t dp_wdata, // Data port write data
    output logic dp_wready, // Data port accepts
    output logic [atxs_pkg::SER_COUNT-1:0] ser_out, // Serial data per serializer
    output logic bit_tick, // Bit rate enable to the encoder
    output atxs_pkg::atxs_dit_s digital_audio_transmit_mode, // Bits for the current subframe
    output logic tx_dma_request, // One-cycle DMA request
    output logic tx_interrupt // Level interrupt
);

    localparam int N = atxs_pkg::SER_COUNT;
    localparam int DMA_LAT = atxs_pkg::DMA_LATENCY_MAX;

    atxs_pkg::atxs_ctrl_s ctrl_reg;
    atxs_pkg::atxs_state_e state_reg;
    atxs_pkg::atxs_word_t buf_reg [N];
    atxs_pkg::atxs_word_t dit_mem_reg [atxs_pkg::DITMEM_WORDS];
    atxs_pkg::atxs_dit_s dit_sel;
    logic [15:0] clkdiv_reg;
    logic [15:0] div_cnt_reg;
    logic [4:0] bit_cnt_reg;
    logic [N-1:0] written_reg;
    logic [N-1:0] pending;
    logic [N-1:0] wr_mask;
    logic [N-1:0] written_now;
    logic [1:0] dp_idx;
    logic [1:0] apb_idx;
    logic [4:0] mem_idx;
    logic [7:0] frame_reg;
    logic [7:0] frame_next;
    logic right_reg;
    logic right_next;
    logic tx_buffer_empty_flag;
    logic underrun_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] tx_interrupt_control;
    logic [31:0] rd_mux;
    logic [31:0] prdata_reg;
    logic bit_en;
    logic xfer;
    logic all_written;
    logic underrun_evt;
    logic dp_acc;
    logic apb_acc;
    logic apb_wr;
    logic apb_rd;
    logic hit;
    logic hit_txbuf;
    logic hit_mem;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Lowest set bit gives the ascending serializer walk
    function automatic logic [1:0] lowest(input logic [N-1:0] m);
        logic [1:0] r;
        r = 2'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = i[1:0];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Bit clock divider and slot timing
    // ------------------------------------------------------------
    // Divider only runs while started, so the first slot is clean
    assign bit_en = (state_reg != atxs_pkg::ST_IDLE) && (div_cnt_reg == clkdiv_reg);
    assign bit_tick = bit_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= 16'h0000;
        end else if (state_reg == atxs_pkg::ST_IDLE || bit_en) begin
            div_cnt_reg <= 16'h0000;
        end else begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
        end
    end

    // State: prime loads the first word, run shifts slot after slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= atxs_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                atxs_pkg::ST_IDLE: begin
                    if (ctrl_reg.enable) begin
                        state_reg <= atxs_pkg::ST_PRIME;
                    end
                end
                atxs_pkg::ST_PRIME: begin
                    if (!ctrl_reg.enable) begin
                        state_reg <= atxs_pkg::ST_IDLE;
                    end else if (bit_en) begin
                        state_reg <= atxs_pkg::ST_RUN;
                    end
                end
                atxs_pkg::ST_RUN: begin
                    if (!ctrl_reg.enable) begin
                        state_reg <= atxs_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= atxs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_reg <= 5'h00;
        end else if (state_reg != atxs_pkg::ST_RUN) begin
            bit_cnt_reg <= 5'h00;
        end else if (bit_en) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    // Transfer once the last bit of the slot has left, for all serializers at once
    assign xfer = bit_en && (state_reg == atxs_pkg::ST_PRIME ||
                  (state_reg == atxs_pkg::ST_RUN && bit_cnt_reg == atxs_pkg::LAST_BIT));

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign apb_acc = psel && penable;
    assign apb_wr = apb_acc && pwrite;
    assign apb_rd = apb_acc && !pwrite;
    assign hit_txbuf = paddr >= atxs_pkg::OFF_TXBUF && paddr < atxs_pkg::OFF_TXBUF_END;
    assign hit_mem = paddr >= atxs_pkg::OFF_DITMEM && paddr < atxs_pkg::OFF_DITMEM_END;
    assign apb_idx = paddr[3:2];
    assign mem_idx = 5'(12'(paddr - atxs_pkg::OFF_DITMEM) >> 2);
    assign hit = (paddr[1:0] == 2'h0) && (hit_txbuf || hit_mem || paddr <= atxs_pkg::OFF_POS);

    // Read mux; reserved bits read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == atxs_pkg::OFF_CTRL) begin
            rd_mux = {25'h0, ctrl_reg};
        end else if (paddr == atxs_pkg::OFF_STATUS) begin
            rd_mux = {30'h0, underrun_reg, tx_buffer_empty_flag};
        end else if (paddr == atxs_pkg::OFF_IRQ_STAT) begin
            rd_mux = {30'h0, irq_stat_reg};
        end else if (paddr == atxs_pkg::OFF_IRQ_MASK) begin
            rd_mux = {30'h0, tx_interrupt_control};
        end else if (paddr == atxs_pkg::OFF_CLKDIV) begin
            rd_mux = {16'h0, clkdiv_reg};
        end else if (paddr == atxs_pkg::OFF_POS) begin
            rd_mux = {21'h0, state_reg, right_reg, frame_reg};
        end else if (hit_txbuf) begin
            rd_mux = buf_reg[apb_idx];
        end else if (hit_mem) begin
            rd_mux = dit_mem_reg[mem_idx];
        end
    end

    // Read data latched in the setup cycle, so prdata is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_reg <= hit ? rd_mux : 32'h0000_0000;
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = apb_acc && !hit;

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= atxs_pkg::CTRL_RESET;
            clkdiv_reg <= atxs_pkg::CLKDIV_RESET;
            tx_interrupt_control <= atxs_pkg::IRQ_MASK_RESET;
        end else if (apb_wr) begin
            if (paddr == atxs_pkg::OFF_CTRL) begin
                ctrl_reg <= atxs_pkg::atxs_ctrl_s'(pwdata[6:0]);
            end else if (paddr == atxs_pkg::OFF_CLKDIV) begin
                clkdiv_reg <= pwdata[15:0];
            end else if (paddr == atxs_pkg::OFF_IRQ_MASK) begin
                tx_interrupt_control <= pwdata[1:0];
            end
        end
    end

    // Status and user words are not double buffered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < atxs_pkg::DITMEM_WORDS; i++) begin
                dit_mem_reg[i] <= 32'h0000_0000;
            end
        end else if (apb_wr && hit_mem && paddr[1:0] == 2'h0) begin
            dit_mem_reg[mem_idx] <= pwdata;
        end
    end

    // ------------------------------------------------------------
    // Buffer writes from either port
    // ------------------------------------------------------------
    // Port select steers which path owns the buffers; requester is not checked
    assign pending = ctrl_reg.active & ~written_reg;
    assign dp_idx = lowest(pending);
    assign dp_wready = !ctrl_reg.port_sel && (pending != '0);
    assign dp_acc = dp_wvalid && dp_wready;

    always_comb begin
        wr_mask = '0;
        if (dp_acc) begin
            wr_mask[dp_idx] = 1'b1;
        end
        if (apb_wr && hit_txbuf && ctrl_reg.port_sel && paddr[1:0] == 2'h0) begin
            wr_mask[apb_idx] = ctrl_reg.active[apb_idx];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < N; i++) begin
                buf_reg[i] <= 32'h0000_0000;
            end
        end else begin
            if (dp_acc) begin
                buf_reg[dp_idx] <= dp_wdata;
            end
            if (apb_wr && hit_txbuf && ctrl_reg.port_sel && paddr[1:0] == 2'h0) begin
                buf_reg[apb_idx] <= pwdata;
            end
        end
    end

    // A write in the transfer cycle counts toward the next slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            written_reg <= '0;
        end else if (xfer) begin
            written_reg <= wr_mask;
        end else begin
            written_reg <= written_reg | wr_mask;
        end
    end

    assign written_now = written_reg | wr_mask;
    assign all_written = (ctrl_reg.active != '0) && ((written_now & ctrl_reg.active) == ctrl_reg.active);
    assign underrun_evt = xfer && (state_reg == atxs_pkg::ST_RUN) &&
                          ((written_reg & ctrl_reg.active) != ctrl_reg.active);

    // ------------------------------------------------------------
    // Ready flag, DMA request and interrupt
    // ------------------------------------------------------------
    // Set wins over both clears so a transfer is never lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buffer_empty_flag <= 1'b0;
        end else if (xfer) begin
            tx_buffer_empty_flag <= 1'b1;
        end else if ((apb_wr && paddr == atxs_pkg::OFF_STATUS && pwdata[atxs_pkg::STAT_EMPTY_BIT]) ||
                     all_written) begin
            tx_buffer_empty_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            underrun_reg <= 1'b0;
        end else if (underrun_evt) begin
            underrun_reg <= 1'b1;
        end else if (apb_wr && paddr == atxs_pkg::OFF_STATUS && pwdata[atxs_pkg::STAT_UNDERRUN_BIT]) begin
            underrun_reg <= 1'b0;
        end
    end

    // Request on every transfer, whatever the flag held before
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_dma_request <= 1'b0;
        end else begin
            tx_dma_request <= xfer;
        end
    end

    // Sticky events, cleared by reading the event register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= 2'h0;
        end else begin
            irq_stat_reg <= ((apb_rd && paddr == atxs_pkg::OFF_IRQ_STAT) ? 2'h0 : irq_stat_reg) |
                            {underrun_evt, xfer};
        end
    end

    assign tx_interrupt = |(irq_stat_reg & tx_interrupt_control);

    // ------------------------------------------------------------
    // Block position and subframe bits
    // ------------------------------------------------------------
    // Position names the slot now loaded into the shift registers
    always_comb begin
        if (state_reg == atxs_pkg::ST_PRIME) begin
            frame_next = 8'h00;
            right_next = 1'b0;
        end else if (right_reg) begin
            frame_next = (frame_reg == atxs_pkg::LAST_FRAME) ? 8'h00 : frame_reg + 8'h01;
            right_next = 1'b0;
        end else begin
            frame_next = frame_reg;
            right_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_reg <= 8'h00;
            right_reg <= 1'b0;
            digital_audio_transmit_mode <= '0;
        end else if (xfer) begin
            frame_reg <= frame_next;
            right_reg <= right_next;
            digital_audio_transmit_mode <= ctrl_reg.dit_mode ? dit_sel : '0;
        end
    end

    atxs_bitsel u_bitsel (
        .mem(dit_mem_reg),
        .frame(frame_next),
        .right(right_next),
        .digital_audio_transmit_mode(dit_sel)
    );

    // One shift register per serializer; inactive ones send zeros
    for (genvar g = 0; g < N; g++) begin : g_ser
        atxs_shifter u_shifter (
            .pclk(pclk),
            .presetn(presetn),
            .load(xfer),
            .shift(bit_en),
            .load_data(ctrl_reg.active[g] ? buf_reg[g] : 32'h0000_0000),
            .bit_out(ser_out[g])
        );
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_EMPTY_SETS: assert property (xfer |=> tx_buffer_empty_flag)
        else $error("empty flag not set after transfer");
    AST_W1C_CLEARS: assert property (apb_wr && paddr == atxs_pkg::OFF_STATUS && pwdata[0] && !xfer
        |=> !tx_buffer_empty_flag)
        else $error("write one did not clear empty flag");
    AST_ALL_WRITTEN: assert property (tx_buffer_empty_flag && all_written && !xfer
        |=> !tx_buffer_empty_flag)
        else $error("flag stayed set after all serializers written");
    AST_DMA_LATENCY: assert property (xfer |-> ##[1:DMA_LAT] tx_dma_request)
        else $error("DMA request late");
    AST_DMA_CAUSE: assert property (tx_dma_request |-> $past(xfer) && tx_buffer_empty_flag)
        else $error("DMA request without transfer");
    AST_DMA_AGAIN: assert property (tx_buffer_empty_flag && xfer |=> tx_dma_request)
        else $error("no request while flag already set");
    AST_DMA_SINGLE: assert property (tx_dma_request |=> !tx_dma_request)
        else $error("more than one request per transfer");
    AST_IRQ_ON_SET: assert property (xfer && tx_interrupt_control[0] |=> tx_interrupt)
        else $error("interrupt missing on enabled flag set");
    AST_PREAMBLE_B: assert property (xfer && ctrl_reg.dit_mode && frame_next == 8'h00 && !right_next
        |=> digital_audio_transmit_mode.preamble == atxs_pkg::PRE_B && frame_reg == 8'h00)
        else $error("block start preamble wrong");
    AST_CS_LEFT: assert property (xfer && ctrl_reg.dit_mode && !right_next
        |=> digital_audio_transmit_mode.cs_bit == $past(dit_mem_reg[atxs_pkg::BANK_CS_L + int'(frame_next[7:5])][frame_next[4:0]]))
        else $error("left channel status bit wrong");
    AST_DP_PORT: assert property (dp_acc |=> buf_reg[$past(dp_idx)] == $past(dp_wdata))
        else $error("data port word missed its serializer");

    COV_XFER_FLAG_SET: cover property (tx_buffer_empty_flag && xfer);
    COV_ALL_WRITTEN: cover property (tx_buffer_empty_flag && all_written ##1 !tx_buffer_empty_flag);
    COV_UNDERRUN: cover property (underrun_evt);
    COV_BLOCK_WRAP: cover property (xfer && frame_reg == atxs_pkg::LAST_FRAME && right_reg);

endmodule

// ### common/atxs_pkg.sv
// Purpose: Shared constants and types for the audio transmit ready and status block
// Assumes: 32-bit APB data, four serializers, one clock domain
// Notes: All offsets are byte addresses on the APB register map

package atxs_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int SER_COUNT = 4;
    localparam int DITMEM_WORDS = 24;
    localparam logic [7:0] LAST_FRAME = 8'hBF;
    localparam logic [4:0] LAST_BIT = 5'h1F;
    localparam int DMA_LATENCY_MAX = 5;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;
    localparam logic [11:0] OFF_CLKDIV = 12'h010;
    localparam logic [11:0] OFF_POS = 12'h014;
    localparam logic [11:0] OFF_TXBUF = 12'h020;
    localparam logic [11:0] OFF_TXBUF_END = 12'h030;
    localparam logic [11:0] OFF_DITMEM = 12'h040;
    localparam logic [11:0] OFF_DITMEM_END = 12'h0A0;

    // Word index of each bank inside the status and user bit memory
    localparam int BANK_CS_L = 0;
    localparam int BANK_CS_R = 6;
    localparam int BANK_UD_L = 12;
    localparam int BANK_UD_R = 18;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int STAT_EMPTY_BIT = 0;
    localparam int STAT_UNDERRUN_BIT = 1;
    localparam logic [15:0] CLKDIV_RESET = 16'h0003;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic [31:0] atxs_word_t;

    typedef enum logic [1:0] {
        PRE_B = 2'h0,
        PRE_M = 2'h1,
        PRE_W = 2'h2
    } atxs_pre_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PRIME = 2'b01,
        ST_RUN = 2'b11
    } atxs_state_e;

    typedef struct packed {
        logic [3:0] active;
        logic port_sel;
        logic dit_mode;
        logic enable;
    } atxs_ctrl_s;

    localparam atxs_ctrl_s CTRL_RESET = 7'h00;

    typedef struct packed {
        logic cs_bit;
        logic user_bit;
        atxs_pre_e preamble;
    } atxs_dit_s;

endpackage

// ### logic/atxs_shifter.sv
// Purpose: One serializer shift register, LSB first
// Assumes: load and shift are one-cycle enables from the slot timer
// Notes: Load wins over shift when both arrive together
`timescale 1ns/1ps

module atxs_shifter (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic load, // Take a new word
    input wire logic shift, // Advance one bit
    input wire atxs_pkg::atxs_word_t load_data, // Word from the data buffer
    output logic bit_out // Serial data
);

    atxs_pkg::atxs_word_t sr_reg;

    // ------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------
    // Serial bit is the register LSB, so it is a flop output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_reg <= 32'h0000_0000;
        end else if (load) begin
            sr_reg <= load_data;
        end else if (shift) begin
            sr_reg <= {1'b0, sr_reg[31:1]};
        end
    end

    assign bit_out = sr_reg[0];

endmodule

// ### logic/atxs_bitsel.sv
// Purpose: Pick channel status, user bit and preamble for one subframe
// Assumes: frame is 0 to 191, right is high for the second subframe
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ps

module atxs_bitsel (
    input wire atxs_pkg::atxs_word_t mem [atxs_pkg::DITMEM_WORDS], // Status and user words
    input wire logic [7:0] frame, // Frame within the block
    input wire logic right, // Right subframe
    output atxs_pkg::atxs_dit_s digital_audio_transmit_mode // Selected bits
);

    logic [2:0] word_idx;
    logic [4:0] bit_idx;
    int cs_base;
    int ud_base;

    // ------------------------------------------------------------
    // Bit selection
    // ------------------------------------------------------------
    // Word is frame div 32, bit is frame mod 32
    always_comb begin
        word_idx = frame[7:5];
        bit_idx = frame[4:0];
        cs_base = right ? atxs_pkg::BANK_CS_R : atxs_pkg::BANK_CS_L;
        ud_base = right ? atxs_pkg::BANK_UD_R : atxs_pkg::BANK_UD_L;
        digital_audio_transmit_mode.cs_bit = mem[cs_base + int'(word_idx)][bit_idx];
        digital_audio_transmit_mode.user_bit = mem[ud_base + int'(word_idx)][bit_idx];
        // Block start is marked only on the left subframe of frame 0
        if (right) begin
            digital_audio_transmit_mode.preamble = atxs_pkg::PRE_W;
        end else if (frame == 8'h00) begin
            digital_audio_transmit_mode.preamble = atxs_pkg::PRE_B;
        end else begin
            digital_audio_transmit_mode.preamble = atxs_pkg::PRE_M;
        end
    end

endmodule

// ### tb/atxs_servicer.sv
// Purpose: Servicer model feeding the data port after each DMA request
// Assumes: one word per cycle; on low models a stalled servicer
// Notes: Idle data toggles so a stale word never looks valid
`timescale 1ns/1ps

module atxs_servicer (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic on, // Answer requests
    input wire logic req, // DMA request
    input wire logic rdy, // Data port ready
    input wire logic [3:0] act, // Active serializer mask
    output logic vld, // Write request
    output atxs_pkg::atxs_word_t dat // Write data
);
    logic [2:0] left_n;
    logic [2:0] left_after;
    // Words still owed this slot once this edge's word is taken
    assign left_after = left_n - 3'(vld && rdy);
    // One word per active serializer; a request is never withdrawn untaken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vld <= 1'b0;
            dat <= 32'h0;
            left_n <= 3'h0;
        end else begin
            left_n <= (req && on) ? 3'($countones(act)) : left_after;
            vld <= (req && on) ? (act != 4'h0) : (left_after != 3'h0);
            if (!vld || rdy) dat <= vld ? $urandom : ~dat;
        end
    end
endmodule

// ### tb/atxs_top_tb.sv
// Purpose: Self-checking bench for the transmit ready and status block
// Assumes: divider set to 0, so one slot is 32 clocks
// Notes: The servicer model drives the data port
`timescale 1ns/1ps

module atxs_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, on = 1;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r, w[4];
    logic pready, pslverr, dvl, drdy, dma, irq, bt, se;
    logic [3:0][31:0] eb = '0, ld = '0;
    int nw = 0;
    logic [3:0] so;
    atxs_pkg::atxs_word_t dd;
    atxs_pkg::atxs_dit_s digital_audio_transmit_mode;
    int n_errors = 0, n_checks = 0, cyc = 0, t0, k, f;
    // Clock and cycle count
    always #4 pclk = ~pclk;
    always @(posedge pclk) cyc++;
    atxs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dp_wvalid(dvl), .dp_wdata(dd), .dp_wready(drdy), .ser_out(so), .bit_tick(bt), .digital_audio_transmit_mode(digital_audio_transmit_mode),
        .tx_dma_request(dma), .tx_interrupt(irq));
    atxs_servicer srv_u (.pclk(pclk), .presetn(presetn), .on(on), .req(dma), .rdy(drdy), .act(f[3:0]),
        .vld(dvl), .dat(dd));
    // Index of the n-th active serializer, lowest first
    function automatic int nth(logic [3:0] m, int n);
        int c = 0;
        for (int i = 0; i < 4; i++) begin
            if (m[i]) begin
                if (c == n) return i;
                c++;
            end
        end
        return 0;
    endfunction
    // Expected serial bit b of every serializer in the current slot
    function automatic logic [3:0] sbits(int b);
        logic [3:0] v;
        for (int g = 0; g < 4; g++) begin
            v[g] = f[g] && ld[g][b];
        end
        return v;
    endfunction
    // Data port words by ascending active serializer; snapshot at each request
    always @(posedge pclk) begin
        if (dma) begin
            nw <= 0;
            ld <= eb;
        end else if (dvl && drdy) begin
            eb[nth(f[3:0], nw)] <= dd;
            nw <= nw + 1;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data lands in r
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitdma();
        do @(negedge pclk); while (dma !== 1'b1);
    endtask
    function automatic atxs_pkg::atxs_pre_e pre_of(int s);
        return (s % 2) ? atxs_pkg::PRE_W : (s == 0) ? atxs_pkg::PRE_B : atxs_pkg::PRE_M;
    endfunction
    task report_and_stop();
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog, far beyond the few hundred clocks the run needs
    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'hB6B6));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, atxs_pkg::OFF_CLKDIV, '0);
        chk(r, 32'h3);
        chk(se, 1'b0);
        for (k = 0; k < 4; k++) begin
            w[k] = $urandom;
            apb(1, atxs_pkg::OFF_DITMEM + 12'(24 * k), w[k]);
        end
        apb(1, atxs_pkg::OFF_IRQ_MASK, 32'h1);
        apb(1, atxs_pkg::OFF_CLKDIV, '0);
        f = $urandom_range(15, 1);
        chk(irq, 1'b0);
        apb(1, atxs_pkg::OFF_CTRL, 32'(f * 8 + 3));
        // Slots of frames 0 to 3, left and right
        for (k = 0; k < 8; k++) begin
            waitdma();
            if (k > 0) chk(32'(cyc - t0), 32'h20);
            t0 = cyc;
            chk({digital_audio_transmit_mode.preamble, digital_audio_transmit_mode.cs_bit, digital_audio_transmit_mode.user_bit}, {pre_of(k), w[k % 2][k / 2], w[2 + k % 2][k / 2]});
            chk(irq, 1'b1);
            repeat (k + 1) @(negedge pclk);
            chk({bt, so}, {1'b1, sbits(k + 1)});
        end
        apb(0, atxs_pkg::OFF_IRQ_STAT, '0);
        chk(r[0], 1'b1);
        @(negedge pclk);
        chk(irq, 1'b0);
        repeat (8) @(posedge pclk);
        apb(0, atxs_pkg::OFF_STATUS, '0);
        chk(r[1:0], 2'h0);
        // Stalled servicer: flag stays, underrun follows
        on <= 1'b0;
        waitdma();
        waitdma();
        apb(0, atxs_pkg::OFF_STATUS, '0);
        chk(r[1:0], 2'h3);
        apb(1, atxs_pkg::OFF_STATUS, 32'h3);
        apb(0, atxs_pkg::OFF_STATUS, '0);
        chk(r[1:0], 2'h0);
        apb(1, atxs_pkg::OFF_IRQ_MASK, '0);
        apb(0, atxs_pkg::OFF_IRQ_STAT, '0);
        waitdma();
        chk(irq, 1'b0);
        apb(1, atxs_pkg::OFF_CTRL, 32'(f * 8 + 5));
        @(negedge pclk);
        chk(drdy, 1'b0);
        w[0] = $urandom;
        apb(1, atxs_pkg::OFF_TXBUF, w[0]);
        apb(0, atxs_pkg::OFF_TXBUF, '0);
        chk(r, w[0]);
        waitdma();
        chk(digital_audio_transmit_mode, '0);
        apb(0, 12'h018, '0);
        chk(se, 1'b1);
        chk(r, 32'h0);
        report_and_stop();
    end
endmodule
